/* uart_fc_pkg.sv */
package uart_fc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DIV_LOW      = 8'h08;
    localparam logic [7:0] OFS_DIV_HIGH     = 8'h09;
    localparam logic [7:0] OFS_ENH_FUNC     = 8'h0a;
    localparam logic [7:0] OFS_RESUME_FIRST = 8'h0b;
    localparam logic [7:0] OFS_RESUME_SEC   = 8'h0c;
    localparam logic [7:0] OFS_PAUSE_FIRST  = 8'h0d;
    localparam logic [7:0] OFS_PAUSE_SEC    = 8'h0e;
    localparam logic [7:0] OFS_FC_LOW       = 8'h12;
    localparam logic [7:0] OFS_FC_HIGH      = 8'h13;
    localparam logic [7:0] OFS_FC_STATUS    = 8'h20;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DIV_LOW  = 8'h00;
    localparam logic [7:0] RST_DIV_HIGH = 8'h00;
    localparam logic [7:0] RST_ENH_FUNC = 8'h00;
    localparam logic [7:0] RST_CHAR     = 8'h00;
    localparam logic [7:0] RST_TRIGGER  = 8'h00;

    // ------------------------------------------------------------
    // in-band mode codes and status bit positions
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_SECOND = 2'h1;
    localparam logic [1:0] MODE_FIRST  = 2'h2;
    localparam logic [1:0] MODE_BOTH   = 2'h3;

    localparam int STS_TX_PAUSED = 0;
    localparam int STS_RTS_FORCE = 1;
    localparam int STS_PAUSE_OUT = 2;
    localparam int STS_SPEC_DET  = 3;

    // ------------------------------------------------------------
    // carriers; in enh_func_t field order gives bit positions 7..0
    // ------------------------------------------------------------
    typedef struct packed {
        logic       autoCts;      // bit 7
        logic       autoRts;      // bit 6
        logic       specDetEn;    // bit 5
        logic       enhanced;     // bit 4
        logic [1:0] txMode;       // bits 3:2
        logic [1:0] rxMode;       // bits 1:0
    } enh_func_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } char_evt_t;

    typedef struct packed {
        logic [7:0] resumeFirst;
        logic [7:0] resumeSecond;
        logic [7:0] pauseFirst;
        logic [7:0] pauseSecond;
    } flow_chars_t;

endpackage

/* flow_char_match.sv */
`timescale 1ns/1ps
module flow_char_match
    import uart_fc_pkg::*;
(
    input  wire logic [7:0]  rxChar,
    input  wire logic [1:0]  useSet,
    input  wire flow_chars_t chars,
    output logic             isPause,
    output logic             isResume
);
    // useSet bit 1 selects the first pair, bit 0 the second pair
    always_comb begin
        isPause  = (useSet[1] && rxChar == chars.pauseFirst)
                || (useSet[0] && rxChar == chars.pauseSecond);
        isResume = (useSet[1] && rxChar == chars.resumeFirst)
                || (useSet[0] && rxChar == chars.resumeSecond);
    end
endmodule

/* fill_hysteresis.sv */
`timescale 1ns/1ps
module fill_hysteresis
    import uart_fc_pkg::*;
#(
    parameter int FILL_W      = 8,
    parameter bit STRICT_HIGH = 1'b0
)(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              enable,
    input  wire logic [FILL_W-1:0] fill,
    input  wire logic [FILL_W-1:0] highLevel,
    input  wire logic [FILL_W-1:0] lowLevel,
    output logic                   active_ff,
    output logic                   setPulse,
    output logic                   releasePulse
);
    logic aboveHigh;
    logic belowLow;

    assign aboveHigh    = STRICT_HIGH ? (fill > highLevel)
                                      : (fill >= highLevel);
    assign belowLow     = fill < lowLevel;
    assign setPulse     = enable && !active_ff && aboveHigh;
    assign releasePulse = enable && active_ff && belowLow;

    // disabling drops the state so no stale release fires later
    always_ff @(posedge clock) begin
        if (rst || !enable) begin
            active_ff <= 1'b0;
        end else if (setPulse) begin
            active_ff <= 1'b1;
        end else if (releasePulse) begin
            active_ff <= 1'b0;
        end
    end
endmodule

/* uart_flow_ctrl.sv */
// Operation
// R1: divisor low byte register, resets zero
// R2: divisor high byte register, resets zero
// R3: divisor is high byte over low byte
// R4: pause match stops transmit after current char
// R5: resume match restarts paused transmit
// R6: receive mode: off, second, first pair
// R7: receive both pairs when mode three, tx on
// R8: software avoids receive three with tx off
// R9: send pause above high, resume below low
// R10: software sets enhanced before tx in-band
// R11: transmit mode: off, second, first pair
// R12: software never writes transmit mode three
// R13: enhanced bit enables extras, resets zero
// R14: detect either pause char, raise interrupt
// R15: software enables detection with in-band
// R16: rts high when fill reaches high level
// R17: rts released when fill below low level
// R18: cts high withholds transmission
// R19: four flow character registers, reset zero
// R20: low and high trigger registers, reset zero
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module uart_flow_ctrl
    import uart_fc_pkg::*;
#(
    parameter int FILL_W = 8
)(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire reg_req_t          regReq,
    output logic [7:0]             rdData_ff,
    input  wire char_evt_t         rxEvt,
    input  wire logic [FILL_W-1:0] rxFillLevel,
    input  wire logic              ctsN,
    input  wire logic              rtsAssert,
    input  wire logic              insertAck,
    output char_evt_t              insertReq_ff,
    output logic                   txEnable,
    output logic                   rtsN,
    output logic                   specCharIrq,
    output logic [15:0]            baudDivisor
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (FILL_W < 1 || FILL_W > 8) begin : g_bad_fill
        $error("FILL_W must lie between 1 and 8");
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0]  divLow_ff;
    logic [7:0]  divHigh_ff;
    enh_func_t   enhFunc_ff;
    flow_chars_t chars_ff;
    logic [7:0]  fcLow_ff;
    logic [7:0]  fcHigh_ff;
    logic        txPaused_ff;
    logic        specDet_ff;
    logic        pauseOut_ff;
    logic        rtsForce;
    logic        wrHit;
    assign wrHit = regReq.wr;

    always_ff @(posedge clock) begin
        if (rst) begin
            divLow_ff  <= RST_DIV_LOW;                      // [R1]
            divHigh_ff <= RST_DIV_HIGH;                     // [R2]
        end else if (wrHit && regReq.addr == OFS_DIV_LOW) begin
            divLow_ff  <= regReq.wdata;                     // [R1]
        end else if (wrHit && regReq.addr == OFS_DIV_HIGH) begin
            divHigh_ff <= regReq.wdata;                     // [R2]
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            enhFunc_ff <= enh_func_t'(RST_ENH_FUNC);        // [R13]
        end else if (wrHit && regReq.addr == OFS_ENH_FUNC) begin
            enhFunc_ff <= enh_func_t'(regReq.wdata);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            chars_ff <= {4{RST_CHAR}};                      // [R19]
        end else if (wrHit) begin
            case (regReq.addr)
                OFS_RESUME_FIRST: chars_ff.resumeFirst  <= regReq.wdata;
                OFS_RESUME_SEC:   chars_ff.resumeSecond <= regReq.wdata;
                OFS_PAUSE_FIRST:  chars_ff.pauseFirst   <= regReq.wdata;
                OFS_PAUSE_SEC:    chars_ff.pauseSecond  <= regReq.wdata;
                default:          chars_ff <= chars_ff;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            fcLow_ff  <= RST_TRIGGER;                       // [R20]
            fcHigh_ff <= RST_TRIGGER;                       // [R20]
        end else if (wrHit && regReq.addr == OFS_FC_LOW) begin
            fcLow_ff  <= regReq.wdata;
        end else if (wrHit && regReq.addr == OFS_FC_HIGH) begin
            fcHigh_ff <= regReq.wdata;
        end
    end

    assign baudDivisor = {divHigh_ff, divLow_ff};           // [R3]

    // ------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ------------------------------------------------------------
    logic [7:0] statusByte;
    logic [7:0] nxt_rdData;

    always_comb begin
        statusByte = 8'h00;
        statusByte[STS_TX_PAUSED] = txPaused_ff;
        statusByte[STS_RTS_FORCE] = rtsForce;
        statusByte[STS_PAUSE_OUT] = pauseOut_ff;
        statusByte[STS_SPEC_DET]  = specDet_ff;
        case (regReq.addr)
            OFS_DIV_LOW:      nxt_rdData = divLow_ff;
            OFS_DIV_HIGH:     nxt_rdData = divHigh_ff;
            OFS_ENH_FUNC:     nxt_rdData = enhFunc_ff;
            OFS_RESUME_FIRST: nxt_rdData = chars_ff.resumeFirst;
            OFS_RESUME_SEC:   nxt_rdData = chars_ff.resumeSecond;
            OFS_PAUSE_FIRST:  nxt_rdData = chars_ff.pauseFirst;
            OFS_PAUSE_SEC:    nxt_rdData = chars_ff.pauseSecond;
            OFS_FC_LOW:       nxt_rdData = fcLow_ff;
            OFS_FC_HIGH:      nxt_rdData = fcHigh_ff;
            OFS_FC_STATUS:    nxt_rdData = statusByte;
            default:          nxt_rdData = 8'h00;
        endcase
    end

    // data shows only in the cycle after the read strobe
    always_ff @(posedge clock) begin
        if (rst || !regReq.rd) begin
            rdData_ff <= 8'h00;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    // ------------------------------------------------------------
    // received in-band flow control
    // ------------------------------------------------------------
    logic [1:0] rxUse;
    logic       rxPause;
    logic       rxResume;
    logic       detPause;
    logic       txModeOn;

    assign txModeOn = enhFunc_ff.txMode == MODE_SECOND
                   || enhFunc_ff.txMode == MODE_FIRST;

    // mode three with transmit off is illegal; treated as off
    always_comb begin
        case (enhFunc_ff.rxMode)
            MODE_SECOND: rxUse = 2'h1;                      // [R6]
            MODE_FIRST:  rxUse = 2'h2;                      // [R6]
            MODE_BOTH:   rxUse = txModeOn ? 2'h3 : 2'h0;    // [R7]
            default:     rxUse = 2'h0;                      // [R6]
        endcase
    end

    flow_char_match u_rx_match (
        .rxChar   (rxEvt.data),
        .useSet   (rxUse),
        .chars    (chars_ff),
        .isPause  (rxPause),
        .isResume (rxResume)
    );

    flow_char_match u_det_match (
        .rxChar   (rxEvt.data),
        .useSet   (2'h3),
        .chars    (chars_ff),
        .isPause  (detPause),
        .isResume ()
    );

    // pause wins if one character matches both
    always_ff @(posedge clock) begin
        if (rst || rxUse == 2'h0) begin
            txPaused_ff <= 1'b0;
        end else if (rxEvt.valid && rxPause) begin
            txPaused_ff <= 1'b1;                            // [R4]
        end else if (rxEvt.valid && rxResume && txPaused_ff) begin
            txPaused_ff <= 1'b0;                            // [R5]
        end
    end

    // sticky, cleared by a status read; a new match wins over clear
    logic specSet;
    logic specClr;

    assign specSet = rxEvt.valid && detPause
                  && enhFunc_ff.enhanced && enhFunc_ff.specDetEn;
    assign specClr = regReq.rd && regReq.addr == OFS_FC_STATUS;

    always_ff @(posedge clock) begin
        if (rst) begin
            specDet_ff <= 1'b0;
        end else begin
            specDet_ff <= specSet || (specDet_ff && !specClr); // [R14]
        end
    end

    assign specCharIrq = specDet_ff;                        // [R14]

    // ------------------------------------------------------------
    // transmit gating; the transmitter finishes its current char
    // ------------------------------------------------------------
    logic ctsHold;
    assign ctsHold  = enhFunc_ff.enhanced && enhFunc_ff.autoCts && ctsN;
    assign txEnable = !txPaused_ff && !ctsHold;             // [R4] [R18]

    // ------------------------------------------------------------
    // automatic rts and in-band transmit flow control
    // ------------------------------------------------------------
    logic [FILL_W-1:0] hiLvl;
    logic [FILL_W-1:0] loLvl;
    logic              rtsEn;
    logic              txFlowEn;
    logic              sendPause;
    logic              sendResume;

    assign hiLvl    = fcHigh_ff[FILL_W-1:0];
    assign loLvl    = fcLow_ff[FILL_W-1:0];
    assign rtsEn    = enhFunc_ff.enhanced && enhFunc_ff.autoRts;
    assign txFlowEn = enhFunc_ff.enhanced && txModeOn;      // [R13]

    fill_hysteresis #(
        .FILL_W      (FILL_W),
        .STRICT_HIGH (1'b0)
    ) u_rts_hyst (
        .clock        (clock),
        .rst          (rst),
        .enable       (rtsEn),
        .fill         (rxFillLevel),
        .highLevel    (hiLvl),
        .lowLevel     (loLvl),
        .active_ff    (rtsForce),
        .setPulse     (),
        .releasePulse ()
    );

    assign rtsN = !(rtsAssert && !rtsForce);                // [R16] [R17]

    fill_hysteresis #(
        .FILL_W      (FILL_W),
        .STRICT_HIGH (1'b1)
    ) u_tx_hyst (
        .clock        (clock),
        .rst          (rst),
        .enable       (txFlowEn),
        .fill         (rxFillLevel),
        .highLevel    (hiLvl),
        .lowLevel     (loLvl),
        .active_ff    (pauseOut_ff),
        .setPulse     (sendPause),
        .releasePulse (sendResume)
    );

    // one pending character; a newer event replaces an unsent one
    logic [7:0] pauseChar;
    logic [7:0] resumeChar;

    assign pauseChar  = enhFunc_ff.txMode == MODE_FIRST
                      ? chars_ff.pauseFirst : chars_ff.pauseSecond;  // [R11]
    assign resumeChar = enhFunc_ff.txMode == MODE_FIRST
                      ? chars_ff.resumeFirst : chars_ff.resumeSecond; // [R11]

    always_ff @(posedge clock) begin
        if (rst || !txFlowEn) begin
            insertReq_ff <= '0;
        end else if (sendPause) begin
            insertReq_ff <= '{valid: 1'b1, data: pauseChar};   // [R9]
        end else if (sendResume) begin
            insertReq_ff <= '{valid: 1'b1, data: resumeChar};  // [R9]
        end else if (insertAck) begin
            insertReq_ff.valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_div_write_low: assert property (                        // [R1]
        wrHit && regReq.addr == OFS_DIV_LOW
        |=> baudDivisor[7:0] == $past(regReq.wdata))
        else $error("divisor low byte not stored");
    a_div_high_read: assert property (                        // [R2] [R3]
        regReq.rd && regReq.addr == OFS_DIV_HIGH
        |=> rdData_ff == baudDivisor[15:8])
        else $error("divisor high byte read mismatch");
    a_pause_stops_tx: assert property (                       // [R4]
        rxEvt.valid && rxPause && rxUse != 2'h0
        |=> !txEnable)
        else $error("transmit not paused after pause char");
    a_resume_restart: assert property (                       // [R5]
        rxEvt.valid && rxResume && !rxPause && txPaused_ff
        && rxUse == $past(rxUse) ##1 1'b1
        |-> !txPaused_ff)
        else $error("transmit not resumed after resume char");
    a_mode_both_sel: assert property (                        // [R7]
        enhFunc_ff.rxMode == MODE_BOTH && txModeOn |-> rxUse == 2'h3)
        else $error("both pairs not accepted in mode three");
    a_insert_pause: assert property (                         // [R9]
        sendPause |=> insertReq_ff.valid
        && insertReq_ff.data == $past(pauseChar))
        else $error("pause char not queued above high level");
    a_spec_irq_set: assert property (                         // [R14]
        specSet |=> specCharIrq ##1 (specCharIrq || $past(specClr)))
        else $error("special detect not raised or cleared early");
    a_rts_forced: assert property (                           // [R16]
        rtsEn && rxFillLevel >= hiLvl ##1 rtsEn |-> rtsN)
        else $error("rts not forced high at high level");
    a_rts_release: assert property (                          // [R17]
        rtsForce && rtsEn && rxFillLevel < loLvl ##1 rtsAssert
        |-> !rtsN)
        else $error("rts not released below low level");
    a_cts_holds: assert property (                            // [R18]
        enhFunc_ff.enhanced && enhFunc_ff.autoCts && ctsN |-> !txEnable)
        else $error("transmit allowed while cts inactive");
    c_pause_resume: cover property (
        txPaused_ff ##[1:50] !txPaused_ff);
    c_rts_cycle: cover property (
        rtsForce ##[1:50] !rtsForce);
    c_insert_done: cover property (
        insertReq_ff.valid && insertAck ##1 !insertReq_ff.valid);
endmodule

/* line_peer.sv */
`timescale 1ns/1ps
module line_peer
    import uart_fc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire char_evt_t  sendChar,
    input  wire logic       ctsHold,
    input  wire logic [3:0] ackDelay,
    input  wire char_evt_t  insertReq,
    output char_evt_t       rxEvt,
    output logic            ctsN,
    output logic            insertAck
);
    logic [7:0] lastChar;
    logic [3:0] waitCnt;

    // ----------------------------------------
    // remote sender and its cts line
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            rxEvt    <= '0;
            lastChar <= 8'h00;
        end else if (sendChar.valid) begin
            rxEvt    <= sendChar;
            lastChar <= sendChar.data;
        end else begin
            // idle data flips every cycle, back to the last byte every second cycle
            rxEvt    <= '{valid: 1'b0, data: ~lastChar};
            lastChar <= ~lastChar;
        end
    end

    always_ff @(posedge clock) begin
        ctsN <= ctsHold;
    end

    // ----------------------------------------
    // transmitter taking in-band characters
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst || insertAck) begin
            insertAck <= 1'b0;
            waitCnt   <= 4'h0;
        end else if (insertReq.valid) begin
            // slow acks stand for a character still on the wire
            if (waitCnt >= ackDelay)
                insertAck <= 1'b1;
            else
                waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench
    import uart_fc_pkg::*;
;
    localparam logic [7:0] RF   = 8'h11;
    localparam logic [7:0] RS   = 8'h12;
    localparam logic [7:0] PF   = 8'h13;
    localparam logic [7:0] PS   = 8'h14;
    localparam logic [7:0] LOWT = 8'h04;
    localparam logic [7:0] HIT  = 8'h0a;
    localparam logic [7:0] OFS [9] = '{OFS_DIV_LOW, OFS_DIV_HIGH,
        OFS_ENH_FUNC, OFS_RESUME_FIRST, OFS_RESUME_SEC, OFS_PAUSE_FIRST,
        OFS_PAUSE_SEC, OFS_FC_LOW, OFS_FC_HIGH};
    localparam logic [7:0] VAL [9] = '{8'h00, 8'h00, 8'h00, RF, RS, PF,
        PS, LOWT, HIT};
    // efr, foreign pause, pause, foreign resume, resume
    // mode three only beside tx mode 01/10; tx mode three never
    localparam logic [39:0] RX_TAB [4] = '{
        {8'h21, PF, PS, RF, RS}, {8'h22, PS, PF, RS, RF},
        {8'h27, 8'h55, PF, 8'h55, RS}, {8'h2b, 8'h55, PS, 8'h55, RF}};

    logic        clock;
    logic        rst;
    reg_req_t    regReq;
    logic [7:0]  rdData_ff;
    char_evt_t   rxEvt;
    char_evt_t   sendChar;
    char_evt_t   insertReq_ff;
    logic [7:0]  rxFillLevel;
    logic        ctsN;
    logic        ctsHold;
    logic        rtsAssert;
    logic        insertAck;
    logic        txEnable;
    logic        rtsN;
    logic        specCharIrq;
    logic [15:0] baudDivisor;
    logic [3:0]  ackDelay;
    logic        rdPend;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [39:0] row;
    logic [7:0]  rdQ [$];
    logic [7:0]  insQ [$];
    int          num_errors;
    int          checks;
    int          insCount;

    uart_flow_ctrl #(.FILL_W(8)) i_uart_flow_ctrl (
        .clock(clock), .rst(rst), .regReq(regReq), .rdData_ff(rdData_ff),
        .rxEvt(rxEvt), .rxFillLevel(rxFillLevel), .ctsN(ctsN),
        .rtsAssert(rtsAssert), .insertAck(insertAck),
        .insertReq_ff(insertReq_ff), .txEnable(txEnable), .rtsN(rtsN),
        .specCharIrq(specCharIrq), .baudDivisor(baudDivisor));

    line_peer i_line_peer (
        .clock(clock), .rst(rst), .sendChar(sendChar), .ctsHold(ctsHold),
        .ackDelay(ackDelay), .insertReq(insertReq_ff), .rxEvt(rxEvt),
        .ctsN(ctsN), .insertAck(insertAck));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic checkBit(string what, logic seen, logic exp);
        check(what, {15'h0000, seen}, {15'h0000, exp});
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // strobes are left standing so accesses run back to back
    task automatic regWrite(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask

    task automatic regRead(logic [7:0] a, logic [7:0] exp);
        @(posedge clock);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        rdQ.push_back(exp);
    endtask

    task automatic idle();
        @(posedge clock);
        regReq <= '0;
    endtask

    task automatic enhanced_function_control(logic [7:0] v);
        regWrite(OFS_ENH_FUNC, v);
        idle();
    endtask

    task automatic sendRx(logic [7:0] ch);
        @(posedge clock);
        sendChar <= '{valid: 1'b1, data: ch};
        @(posedge clock);
        sendChar <= '0;
        tick(2);
    endtask

    task automatic setFill(logic [7:0] v);
        @(posedge clock);
        rxFillLevel <= v;
    endtask

    task automatic waitIns(int target);
        for (int i = 0; i < 64 && insCount < target; i++)
            @(posedge clock);
        if (insCount < target) begin
            num_errors++;
            $display("Error insert count expected %0d seen %0d", target,
                insCount);
            give_verdict();
        end
    endtask

    // ----------------------------------------
    // scoreboard: oldest note against each result
    // ----------------------------------------
    always @(posedge clock) begin
        rdPend <= regReq.rd & ~rst;
        if (rdPend)
            check("read data", {8'h00, rdData_ff},
                {8'h00, rdQ.pop_front()});
        if (insertAck && insertReq_ff.valid) begin
            check("inserted char", {8'h00, insertReq_ff.data},
                {8'h00, insQ.pop_front()});
            insCount++;
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        $display("Error watchdog expected end seen hang");
        give_verdict();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        regReq = '0;
        sendChar = '0;
        rxFillLevel = 8'h00;
        ctsHold = 1'b0;
        rtsAssert = 1'b1;
        ackDelay = 4'h0;
        num_errors = 0;
        checks = 0;
        insCount = 0;
        lo = 8'($urandom(32'h408dbd2c));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        foreach (OFS[i]) regRead(OFS[i], 8'h00);
        regRead(8'h3f, 8'h00);
        idle();
        tick(1);
        check("divisor", baudDivisor, 16'h0000);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            lo = 8'($urandom);
            hi = 8'($urandom);
            regWrite(OFS_DIV_LOW, lo);
            regWrite(OFS_DIV_HIGH, hi);
            regWrite(8'h3f, ~lo);
            regRead(OFS_DIV_LOW, lo);
            regRead(OFS_DIV_HIGH, hi);
            regRead(8'h3f, 8'h00);
            idle();
            tick(1);
            check("divisor", baudDivisor, {hi, lo});
        end
        for (int i = 3; i < 9; i++) regWrite(OFS[i], VAL[i]);
        for (int i = 3; i < 9; i++) regRead(OFS[i], VAL[i]);
        idle();
        $display("test divisor and characters done");
        enhanced_function_control(8'h20);
        sendRx(PF);
        checkBit("tx enable", txEnable, 1'b1);
        for (int m = 0; m < 4; m++) begin
            row = RX_TAB[m];
            enhanced_function_control(row[39:32]);
            sendRx(row[31:24]);
            checkBit("tx enable", txEnable, 1'b1);
            sendRx(row[23:16]);
            checkBit("tx enable", txEnable, 1'b0);
            sendRx(row[15:8]);
            checkBit("tx enable", txEnable, 1'b0);
            sendRx(row[7:0]);
            checkBit("tx enable", txEnable, 1'b1);
            checkBit("special irq", specCharIrq, 1'b0);
        end
        $display("test receive in-band done");
        enhanced_function_control(8'h30);
        sendRx(RS);
        checkBit("special irq", specCharIrq, 1'b0);
        sendRx(PS);
        checkBit("special irq", specCharIrq, 1'b1);
        regRead(OFS_FC_STATUS, 8'h08);
        idle();
        tick(2);
        checkBit("special irq", specCharIrq, 1'b0);
        sendRx(PF);
        checkBit("special irq", specCharIrq, 1'b1);
        regRead(OFS_FC_STATUS, 8'h08);
        idle();
        $display("test special detect done");
        enhanced_function_control(8'h80);
        @(posedge clock);
        ctsHold <= 1'b1;
        tick(2);
        checkBit("tx enable", txEnable, 1'b1);
        enhanced_function_control(8'h90);
        tick(1);
        checkBit("tx enable", txEnable, 1'b0);
        @(posedge clock);
        ctsHold <= 1'b0;
        tick(2);
        checkBit("tx enable", txEnable, 1'b1);
        $display("test cts done");
        enhanced_function_control(8'h50);
        setFill(HIT - 8'h01);
        tick(2);
        checkBit("rts pin", rtsN, 1'b0);
        setFill(HIT);
        tick(2);
        checkBit("rts pin", rtsN, 1'b1);
        setFill(LOWT);
        tick(2);
        checkBit("rts pin", rtsN, 1'b1);
        setFill(LOWT - 8'h01);
        tick(2);
        checkBit("rts pin", rtsN, 1'b0);
        @(posedge clock);
        rtsAssert <= 1'b0;
        tick(1);
        checkBit("rts pin", rtsN, 1'b1);
        $display("test rts done");
        for (int t = 0; t < 2; t++) begin
            // fill parked at the threshold so enabling sends nothing
            setFill(HIT);
            ackDelay <= (t == 0) ? 4'h0 : 4'h6;
            enhanced_function_control(t == 0 ? 8'h34 : 8'h38);
            tick(3);
            checkBit("insert valid", insertReq_ff.valid, 1'b0);
            insQ.push_back(t == 0 ? PS : PF);
            setFill(HIT + 8'h01);
            waitIns(2 * t + 1);
            insQ.push_back(t == 0 ? RS : RF);
            setFill(LOWT);
            tick(3);
            checkBit("insert valid", insertReq_ff.valid, 1'b0);
            setFill(LOWT - 8'h01);
            waitIns(2 * t + 2);
        end
        $display("test transmit in-band done");
        tick(3);
        check("notes left", 16'(rdQ.size() + insQ.size()), 16'h0000);
        give_verdict();
    end
endmodule
